// >>> gpio_function_mux.sv
`timescale 1ns/10ps
`default_nettype none
`include "gpio_map.svh"
module gpio_function_mux #(
    parameter int SILENCE_TIMEOUT_US = `SILENCE_TIMEOUT_US,
    parameter int DOMINANT_TIMEOUT_US = `DOMINANT_TIMEOUT_US,
    parameter int CNT_W = 24
) (
    input wire logic clock_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // pins and analog-side levels, asynchronous
    input wire logic pin1_in_i,
    input wire logic pin2_in_i,
    input wire logic bus_rx_i,
    input wire logic primary_tx_i,
    output logic pin1_out_o,
    output logic pin1_oe_n_o,
    output logic [2:0] pin1_drive_config_o,
    // internal status from neighbouring logic, same clock
    input wire logic pin2_second_tx_i,
    input wire logic interrupt_i,
    input wire logic supply_undervoltage_flag_i,
    input wire logic wake_pattern_i,
    input wire logic wake_frame_i,
    input wire logic bus_biasing_i,
    input wire logic wake_pin_rise_i,
    input wire logic wake_pin_fall_i,
    input wire logic ready_to_transmit_i,
    input wire logic listen_only_i,
    input wire logic auxiliary_inhibit_i,
    // results
    output logic primary_rx_o,
    output logic transmitter_disable_o,
    output logic wake_event_o,
    output logic pin2_polarity_o
);
    localparam int SILENCE_CYCLES = SILENCE_TIMEOUT_US * `CLK_FREQ_MHZ;
    localparam int DOMINANT_CYCLES = DOMINANT_TIMEOUT_US * `CLK_FREQ_MHZ;
    localparam logic [CNT_W-1:0] SILENCE_LIMIT = CNT_W'((SILENCE_CYCLES < 1) ? 1 : SILENCE_CYCLES);
    localparam logic [CNT_W-1:0] DOMINANT_LIMIT = CNT_W'((DOMINANT_CYCLES < 1) ? 1 : DOMINANT_CYCLES);

    logic [7:0] cfg_q;
    logic [1:0] pol_q;
    logic wake_en_q;
    logic [3:0] fault_q;
    logic [3:0] sync_lvl;
    logic pin1_lvl;
    logic pin2_lvl;
    logic bus_rx_lvl;
    logic tx_lvl;
    logic pin1_prev_q;
    logic [4:0] func;
    logic [2:0] drive;
    logic drive_valid;
    logic pin1_pol;
    logic rise;
    logic fall;
    logic src_on;
    logic stat_sel;
    logic stat;
    logic level;
    logic repeat_mode;
    gpio_pkg::drive_kind_t kind;
    logic out_d;
    logic oe_n_d;
    logic [2:0] drv_cfg_d;
    logic [7:0] rdata_d;

    // every outside level passes the three-stage synchroniser before use;
    // bus and transmit lines idle high, so they pass inverted and read recessive while the stages reset
    pin_sync #(
        .W(4)
    ) u_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .async_i({~primary_tx_i, ~bus_rx_i, pin2_in_i, pin1_in_i}),
        .level_o(sync_lvl)
    );

    assign pin1_lvl = sync_lvl[0];
    assign pin2_lvl = sync_lvl[1];
    assign bus_rx_lvl = ~sync_lvl[2];
    assign tx_lvl = ~sync_lvl[3];

    assign func = cfg_q[`CFG_FUNC_MSB:`CFG_FUNC_LSB];
    assign drive = cfg_q[`CFG_DRIVE_MSB:`CFG_DRIVE_LSB];
    // codes above the low-side driver are reserved
    assign drive_valid = (drive <= `DRV_LOW_PU);
    assign pin1_pol = pol_q[0];

    // configuration registers; the polarity register keeps only its two live bits
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cfg_q <= `CFG_RESET;
            pol_q <= `POL_RESET;
            wake_en_q <= 1'b0;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `REG_PIN1_CFG) begin
                cfg_q <= reg_wdata_i;
            end else if (reg_addr_i == `REG_POLARITY) begin
                pol_q <= reg_wdata_i[1:0];
            end else if (reg_addr_i == `REG_WAKE_EN) begin
                wake_en_q <= reg_wdata_i[0];
            end
        end
    end

    // level timers: bit 3 watches for recessive silence, the rest for a dominant clamp
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_timer
            logic [CNT_W-1:0] cnt_q;
            logic watched;
            logic armed;
            logic [CNT_W-1:0] limit;
            if (ch == 3) begin : g_silence
                assign watched = bus_rx_lvl;
                assign armed = 1'b1;
                assign limit = SILENCE_LIMIT;
            end else if (ch == 2) begin : g_bus
                assign watched = ~bus_rx_lvl;
                assign armed = 1'b1;
                assign limit = DOMINANT_LIMIT;
            end else if (ch == 1) begin : g_tx2
                // the second transmit input only exists while pin 2 serves as one
                assign watched = ~pin2_lvl;
                assign armed = pin2_second_tx_i;
                assign limit = DOMINANT_LIMIT;
            end else begin : g_tx
                assign watched = ~tx_lvl;
                assign armed = 1'b1;
                assign limit = DOMINANT_LIMIT;
            end
            // counter saturates, so the flag holds for as long as the condition lasts
            always_ff @(posedge clock_i) begin
                if (rst_i) begin
                    cnt_q <= '0;
                    fault_q[ch] <= 1'b0;
                end else if (!(watched && armed)) begin
                    cnt_q <= '0;
                    fault_q[ch] <= 1'b0;
                end else if (cnt_q < limit) begin
                    cnt_q <= cnt_q + CNT_W'(1);
                    fault_q[ch] <= 1'b0;
                end else begin
                    fault_q[ch] <= 1'b1;
                end
            end
        end
    endgenerate

    // edge detection on the synchronised pin level
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pin1_prev_q <= 1'b0;
        end else begin
            pin1_prev_q <= pin1_lvl;
        end
    end

    assign rise = pin1_lvl & ~pin1_prev_q;
    assign fall = ~pin1_lvl & pin1_prev_q;

    // picks the internal status routed to the pin; unlisted codes route nothing
    always_comb begin
        stat_sel = 1'b1;
        stat = 1'b0;
        case (func)
            `FN_UNDERVOLT: begin
                stat = supply_undervoltage_flag_i;
            end
            `FN_TX_CLAMP: begin
                stat = fault_q[0];
            end
            `FN_TX2_CLAMP: begin
                stat_sel = pin2_second_tx_i;
                stat = fault_q[1];
            end
            `FN_WAKE_PAT: begin
                stat = wake_pattern_i;
            end
            `FN_WAKE_FRAME: begin
                stat = wake_frame_i;
            end
            `FN_BIASING: begin
                stat = bus_biasing_i;
            end
            `FN_WAKE_RISE: begin
                stat = wake_pin_rise_i;
            end
            `FN_WAKE_FALL: begin
                stat = wake_pin_fall_i;
            end
            `FN_READY_TX: begin
                stat = ready_to_transmit_i;
            end
            `FN_LISTEN: begin
                stat = listen_only_i;
            end
            `FN_INHIBIT: begin
                stat = auxiliary_inhibit_i;
            end
            default: begin
                stat_sel = 1'b0;
            end
        endcase
    end

    // function select: decides whether the pin is driven and at what level
    always_comb begin
        src_on = 1'b0;
        level = 1'b0;
        repeat_mode = 1'b0;
        case (func)
            `FN_REPEATER: begin
                repeat_mode = 1'b1;
            end
            `FN_DIG_OUT: begin
                src_on = 1'b1;
                level = pin1_pol;
            end
            `FN_INT: begin
                src_on = 1'b1;
                level = ~interrupt_i ^ pin1_pol;
            end
            `FN_RX2_BOTH, `FN_RX2_ONLY: begin
                // polarity has no effect on the receive copy
                src_on = 1'b1;
                level = bus_rx_lvl;
            end
            default: begin
                src_on = stat_sel;
                level = stat ^ pin1_pol;
            end
        endcase
        // a reserved drive code keeps the pin quiet in every function but the repeater
        if (!drive_valid) begin
            src_on = 1'b0;
        end
    end

    // output stage style from the drive field; open-drain styles drive one level only
    always_comb begin
        case (drive)
            `DRV_PUSH_PULL: kind = gpio_pkg::DRIVE_ALWAYS;
            `DRV_OD_HIGH, `DRV_HIGH_PD: kind = gpio_pkg::DRIVE_HIGH_ONLY;
            `DRV_OD_LOW, `DRV_LOW_PU: kind = gpio_pkg::DRIVE_LOW_ONLY;
            default: kind = gpio_pkg::DRIVE_NONE;
        endcase
    end

    // pin drive for the next cycle
    always_comb begin
        oe_n_d = 1'b1;
        out_d = 1'b0;
        drv_cfg_d = drive_valid ? drive : `DRV_FLOAT;
        if (repeat_mode) begin
            // repeater ignores the drive field and only keeps the present level
            out_d = pin1_lvl;
            drv_cfg_d = `DRV_REPEATER;
        end else if (src_on) begin
            out_d = level;
            case (kind)
                gpio_pkg::DRIVE_ALWAYS: oe_n_d = 1'b0;
                gpio_pkg::DRIVE_HIGH_ONLY: oe_n_d = ~level;
                gpio_pkg::DRIVE_LOW_ONLY: oe_n_d = level;
                default: oe_n_d = 1'b1;
            endcase
        end
    end

    // registered pin outputs
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pin1_out_o <= 1'b0;
            pin1_oe_n_o <= 1'b1;
            pin1_drive_config_o <= `DRV_REPEATER;
        end else begin
            pin1_out_o <= out_d;
            pin1_oe_n_o <= oe_n_d;
            pin1_drive_config_o <= drv_cfg_d;
        end
    end

    // receive path and transmitter disable
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            primary_rx_o <= 1'b1;
            transmitter_disable_o <= 1'b0;
        end else begin
            // only the second-receive-only mode withholds data from the primary output
            primary_rx_o <= (func == `FN_RX2_ONLY && drive_valid) ? 1'b1 : bus_rx_lvl;
            transmitter_disable_o <= (func == `FN_TX_DISABLE) && drive_valid && pin1_lvl;
        end
    end

    // wake-up edge qualification, one pulse per qualifying edge
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            wake_event_o <= 1'b0;
        end else if (!wake_en_q || !drive_valid) begin
            wake_event_o <= 1'b0;
        end else if (func == `FN_EDGE_RISE) begin
            wake_event_o <= rise;
        end else if (func == `FN_EDGE_FALL) begin
            wake_event_o <= fall;
        end else if (func == `FN_EDGE_BOTH) begin
            wake_event_o <= rise | fall;
        end else begin
            wake_event_o <= 1'b0;
        end
    end

    // pin 2 polarity is handed to the pin 2 logic outside this block
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pin2_polarity_o <= 1'b0;
        end else begin
            pin2_polarity_o <= pol_q[1];
        end
    end

    // read mux; reserved bits read zero, unmapped addresses read zero
    always_comb begin
        rdata_d = 8'h00;
        if (reg_addr_i == `REG_PIN1_CFG) begin
            rdata_d = cfg_q;
        end else if (reg_addr_i == `REG_POLARITY) begin
            rdata_d = {6'h00, pol_q};
        end else if (reg_addr_i == `REG_WAKE_EN) begin
            rdata_d = {7'h00, wake_en_q};
        end else if (reg_addr_i == `REG_FAULT) begin
            rdata_d = {ready_to_transmit_i, 3'h0, fault_q};
        end else if (reg_addr_i == `REG_LEVEL) begin
            rdata_d = {6'h00, pin2_lvl, pin1_lvl};
        end
    end

    // read data stands for exactly the cycle after the strobe
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_d;
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// >>> gpio_function_mux_end.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// >>> gpio_function_mux_properties.sv
`timescale 1ns/10ps
`default_nettype none
module gpio_function_mux_properties (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic interrupt_i,
    input wire logic bus_biasing_i,
    input wire logic pin1_out_o,
    input wire logic pin1_oe_n_o,
    input wire logic [2:0] pin1_drive_config_o,
    input wire logic primary_rx_o,
    input wire logic transmitter_disable_o
);
    logic [7:0] cfg_q;
    logic pol_q;
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // shadow of the config and polarity registers, rebuilt from the write port only
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cfg_q <= 8'h60;
            pol_q <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == 8'h42) begin
            cfg_q <= reg_wdata_i;
        end else if (reg_wr_i && reg_addr_i == 8'h45) begin
            pol_q <= reg_wdata_i[0];
        end
    end
    a_rdata_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data not zero outside read answer");
    a_read_cfg_value: assert property ($past(reg_rd_i && reg_addr_i == 8'h42) |-> reg_rdata_o == $past(cfg_q))
        else $error("config readback wrong");
    a_repeater_idle: assert property ($past(cfg_q[4:0]) == 5'h00 |-> pin1_oe_n_o && pin1_drive_config_o == 3'h3)
        else $error("repeater mode drives pin");
    a_dig_out_level: assert property ($past(cfg_q) == 8'h02 |-> !pin1_oe_n_o && pin1_out_o == $past(pol_q))
        else $error("digital output level wrong");
    a_int_out_level: assert property ($past(cfg_q) == 8'h04 |-> pin1_out_o == ($past(pol_q) ^ ~$past(interrupt_i)))
        else $error("interrupt output level wrong");
    a_bias_out_level: assert property ($past(cfg_q) == 8'h0E |-> pin1_out_o == ($past(pol_q) ^ $past(bus_biasing_i)))
        else $error("bias status output wrong");
    a_rx2_only_rx: assert property ($past(cfg_q[4:0]) == 5'h08 |-> primary_rx_o)
        else $error("primary receive not held recessive");
    a_drive_cfg_out: assert property ($past(cfg_q[4:0]) == 5'h02 && $past(cfg_q[7:5]) < 3'h5
        |-> pin1_drive_config_o == $past(cfg_q[7:5]))
        else $error("drive style output wrong");
    a_reserved_quiet: assert property (($past(cfg_q[4:0]) inside {5'h05, 5'h07} || $past(cfg_q[4:0]) > 5'h16
        || ($past(cfg_q[7:5]) > 3'h4 && $past(cfg_q[4:0]) != 5'h00))
        |-> pin1_oe_n_o && !pin1_out_o && !transmitter_disable_o)
        else $error("reserved code left pin active");
endmodule
bind gpio_function_mux gpio_function_mux_properties u_gpio_function_mux_properties (.clock_i(clock_i),
    .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .interrupt_i(interrupt_i), .bus_biasing_i(bus_biasing_i), .pin1_out_o(pin1_out_o),
    .pin1_oe_n_o(pin1_oe_n_o), .pin1_drive_config_o(pin1_drive_config_o), .primary_rx_o(primary_rx_o),
    .transmitter_disable_o(transmitter_disable_o));
`default_nettype wire

// >>> gpio_map.svh
// Summary of operation
// - Bus-silence flag, status bit 3, set after bus silent beyond the silence timeout.
// - Status bit 2 reads 1 while the bus is clamped dominant.
// - Status bit 1 reads 1 while the second transmit input is clamped dominant.
// - Status bit 0 reads 1 while the primary transmit input is clamped dominant.
// - Pin 1 polarity is ignored while pin 1 is a second receive output.
// - Pin level status: pin 2 in bit 1, pin 1 in bit 0, 1 is high.
// - Drive configuration in bits 7:5, reset 011; codes 101 to 111 reserved.
// - Function code zero, the reset value, runs the pin as a repeater.
// - Code 0x02 drives a digital output equal to the polarity bit.
// - Code 0x03: a high pin disables the transmitter.
// - Code 0x04: interrupt output, active low at polarity 0, active high at 1.
// - Code 0x06: bus data goes to the pin and the primary receive output.
// - Code 0x08: bus data goes only to the pin.
// - Codes 0x09 to 0x12 output internal status signals in the listed order.
// - Code 0x0B shows second-transmit clamp only when pin 2 is second transmit.
// - Bus biasing status at default polarity drives the pin high while biasing.
// - Codes 0x13 and 0x14 qualify rising or falling edges for wake-up.
// - Status outputs are active high at polarity 0, active low at 1.
// - Code 0x15 qualifies both edges, 0x16 drives inhibit; 0x17 to 0x1F reserved.
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH

`define REG_PIN1_CFG 8'h42
`define REG_POLARITY 8'h45
`define REG_WAKE_EN 8'hF0
`define REG_FAULT 8'h72
`define REG_LEVEL 8'h74

`define CFG_RESET 8'h60
`define POL_RESET 2'h0
`define CFG_DRIVE_MSB 7
`define CFG_DRIVE_LSB 5
`define CFG_FUNC_MSB 4
`define CFG_FUNC_LSB 0

`define DRV_PUSH_PULL 3'h0
`define DRV_OD_HIGH 3'h1
`define DRV_HIGH_PD 3'h2
`define DRV_OD_LOW 3'h3
`define DRV_LOW_PU 3'h4
`define DRV_REPEATER 3'h3
`define DRV_FLOAT 3'h0

`define FN_REPEATER 5'h00
`define FN_DIG_OUT 5'h02
`define FN_TX_DISABLE 5'h03
`define FN_INT 5'h04
`define FN_RX2_BOTH 5'h06
`define FN_RX2_ONLY 5'h08
`define FN_UNDERVOLT 5'h09
`define FN_TX_CLAMP 5'h0A
`define FN_TX2_CLAMP 5'h0B
`define FN_WAKE_PAT 5'h0C
`define FN_WAKE_FRAME 5'h0D
`define FN_BIASING 5'h0E
`define FN_WAKE_RISE 5'h0F
`define FN_WAKE_FALL 5'h10
`define FN_READY_TX 5'h11
`define FN_LISTEN 5'h12
`define FN_EDGE_RISE 5'h13
`define FN_EDGE_FALL 5'h14
`define FN_EDGE_BOTH 5'h15
`define FN_INHIBIT 5'h16

`define CLK_FREQ_MHZ 50
`define SILENCE_TIMEOUT_US 1000
`define DOMINANT_TIMEOUT_US 1000

`endif

// >>> gpio_pkg.sv
`default_nettype none
package gpio_pkg;
    // how the output stage treats the pin for a given drive configuration
    typedef enum logic [1:0] {
        DRIVE_NONE,
        DRIVE_ALWAYS,
        DRIVE_HIGH_ONLY,
        DRIVE_LOW_ONLY
    } drive_kind_t;
endpackage
`default_nettype wire

// >>> host_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_pin_model (
    input wire logic clock_i,
    input wire logic pin_out_i,
    input wire logic pin_oe_n_i,
    input wire logic [2:0] drive_config_i,
    input wire logic host_val_i,
    input wire logic host_en_i,
    output logic level_o
);
    logic float_q = 1'b0;
    // an unheld wire shows a changing pattern, so a stale level never passes for a real one
    always @(posedge clock_i) float_q <= ~float_q;
    // wire level: device driver first, then the host, then the selected pull resistor
    always_comb begin
        if (!pin_oe_n_i) begin
            level_o = pin_out_i;
        end else if (host_en_i) begin
            level_o = host_val_i;
        end else if (drive_config_i == 3'h1 || drive_config_i == 3'h4) begin
            level_o = 1'b1;
        end else if (drive_config_i == 3'h2) begin
            level_o = 1'b0;
        end else begin
            level_o = float_q;
        end
    end
endmodule
`default_nettype wire

// >>> pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] level_o
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic lvl_q;
            // first stage feeds only the second; the level moves once stages two and three agree
            always_ff @(posedge clock_i) begin
                if (rst_i) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    lvl_q <= 1'b0;
                end else begin
                    s1_q <= async_i[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        lvl_q <= s3_q;
                    end
                end
            end
            assign level_o[i] = lvl_q;
        end
    endgenerate
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, pin2_in_i = 1'b1, bus_rx_i = 1'b1, primary_tx_i = 1'b1;
    logic pin2_second_tx_i = 1'b0, interrupt_i = 1'b0, host_val = 1'b0, host_en = 1'b0, pin1_level, pin2_pol;
    logic [10:0] st = 11'h000;
    logic pin1_out_o, pin1_oe_n_o, primary_rx_o, transmitter_disable_o, wake_event_o;
    logic [2:0] pin1_drive_config_o;
    int miscompares = 0, num_checks = 0, wake_cnt = 0, i, p;
    logic [7:0] rsv [6] = '{8'h05, 8'h07, 8'h17, 8'h1F, 8'hA2, 8'hE9};
    // timeouts shrunk to 50 cycles so fault flags rise within a short run
    gpio_function_mux #(.SILENCE_TIMEOUT_US(1), .DOMINANT_TIMEOUT_US(1)) u_gpio_function_mux (.clock_i(clock_i),
        .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .pin1_in_i(pin1_level), .pin2_in_i(pin2_in_i), .bus_rx_i(bus_rx_i),
        .primary_tx_i(primary_tx_i), .pin1_out_o(pin1_out_o), .pin1_oe_n_o(pin1_oe_n_o),
        .pin1_drive_config_o(pin1_drive_config_o), .pin2_second_tx_i(pin2_second_tx_i), .interrupt_i(interrupt_i),
        .supply_undervoltage_flag_i(st[0]), .wake_pattern_i(st[3]), .wake_frame_i(st[4]), .bus_biasing_i(st[5]),
        .wake_pin_rise_i(st[6]), .wake_pin_fall_i(st[7]), .ready_to_transmit_i(st[8]), .listen_only_i(st[9]),
        .auxiliary_inhibit_i(st[10]), .primary_rx_o(primary_rx_o), .transmitter_disable_o(transmitter_disable_o),
        .wake_event_o(wake_event_o), .pin2_polarity_o(pin2_pol));
    host_pin_model u_host_pin_model (.clock_i(clock_i), .pin_out_i(pin1_out_o), .pin_oe_n_i(pin1_oe_n_o),
        .drive_config_i(pin1_drive_config_o), .host_val_i(host_val), .host_en_i(host_en), .level_o(pin1_level));
    // clock, wake pulse tally
    always #10 clock_i = ~clock_i;
    always @(posedge clock_i) if (wake_event_o === 1'b1) wake_cnt <= wake_cnt + 1;
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        #1 cmp8(reg_rdata_o, e);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic wake_try(input logic [7:0] code, input logic [7:0] exp);
        int n0;
        host_val <= 1'b0;
        wr(8'h42, code);
        wt(10);
        n0 = wake_cnt;
        host_val <= 1'b1;
        wt(10);
        host_val <= 1'b0;
        wt(10);
        cmp8(8'(wake_cnt - n0), exp);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // watchdog: the whole sequence needs about 700 cycles
    initial begin
        repeat (20000) @(posedge clock_i);
        miscompares++;
        print_verdict;
    end
    initial begin
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        rd(8'h42, 8'h60);
        cmp1(pin1_oe_n_o, 1'b1);
        rd(8'h45, 8'h00);
        rd(8'h72, 8'h00);
        wr(8'h45, 8'h02);
        rd(8'h45, 8'h02);
        cmp1(pin2_pol, 1'b1);
        rd(8'h50, 8'h00);
        wr(8'h72, 8'hFF);
        rd(8'h72, 8'h00);
        wr(8'h45, 8'h00);
        $display("registers done");
        host_en <= 1'b1;
        for (i = 0; i < 4; i++) begin
            host_val <= i[0];
            pin2_in_i <= i[1];
            wt(10);
            rd(8'h74, 8'(i));
        end
        wr(8'h42, 8'h03);
        host_val <= 1'b1;
        wt(10);
        cmp1(transmitter_disable_o, 1'b1);
        host_val <= 1'b0;
        wt(10);
        cmp1(transmitter_disable_o, 1'b0);
        $display("pin inputs done");
        wr(8'hF0, 8'h01);
        wake_try(8'h13, 8'h01);
        wake_try(8'h14, 8'h01);
        wake_try(8'h15, 8'h02);
        wr(8'hF0, 8'h00);
        wake_try(8'h15, 8'h00);
        $display("wake done");
        wr(8'h42, 8'h02);
        wt(3);
        cmp1(pin1_oe_n_o, 1'b0);
        cmp1(pin1_out_o, 1'b0);
        wr(8'h45, 8'h01);
        wt(3);
        cmp1(pin1_out_o, 1'b1);
        wr(8'h45, 8'h00);
        wr(8'h42, 8'h22);
        wt(3);
        cmp8({5'h00, pin1_drive_config_o}, 8'h01);
        cmp1(pin1_oe_n_o, 1'b1);
        wr(8'h42, 8'h62);
        wt(3);
        cmp1(pin1_oe_n_o, 1'b0);
        interrupt_i <= 1'b1;
        wr(8'h42, 8'h04);
        wt(3);
        cmp1(pin1_out_o, 1'b0);
        interrupt_i <= 1'b0;
        wt(3);
        cmp1(pin1_out_o, 1'b1);
        for (p = 0; p < 2; p++) begin
            wr(8'h45, 8'(p));
            for (i = 0; i < 11; i++) begin
                if (i != 1 && i != 2) begin
                    wr(8'h42, (i < 10) ? 8'(9 + i) : 8'h16);
                    st <= 11'(1) << i;
                    wt(3);
                    cmp1(pin1_out_o, ~p[0]);
                    cmp1(pin1_oe_n_o, 1'b0);
                    st <= 11'h000;
                    wt(3);
                    cmp1(pin1_out_o, p[0]);
                end
            end
        end
        $display("status outputs done");
        wr(8'h45, 8'h00);
        primary_tx_i <= 1'b0;
        pin2_second_tx_i <= 1'b1;
        pin2_in_i <= 1'b0;
        st <= 11'h100;
        wt(80);
        rd(8'h72, 8'h8B);
        wr(8'h42, 8'h0A);
        wt(3);
        cmp1(pin1_out_o, 1'b1);
        wr(8'h42, 8'h0B);
        wt(3);
        cmp1(pin1_out_o, 1'b1);
        pin2_second_tx_i <= 1'b0;
        wt(3);
        cmp1(pin1_oe_n_o, 1'b1);
        bus_rx_i <= 1'b0;
        primary_tx_i <= 1'b1;
        pin2_in_i <= 1'b1;
        st <= 11'h000;
        wt(80);
        rd(8'h72, 8'h04);
        bus_rx_i <= 1'b1;
        wt(20);
        rd(8'h72, 8'h00);
        $display("fault flags done");
        wr(8'h45, 8'h01);
        wr(8'h42, 8'h06);
        bus_rx_i <= 1'b0;
        wt(10);
        cmp1(pin1_out_o, 1'b0);
        cmp1(primary_rx_o, 1'b0);
        bus_rx_i <= 1'b1;
        wt(10);
        cmp1(pin1_out_o, 1'b1);
        wr(8'h42, 8'h08);
        bus_rx_i <= 1'b0;
        wt(10);
        cmp1(primary_rx_o, 1'b1);
        cmp1(pin1_out_o, 1'b0);
        bus_rx_i <= 1'b1;
        $display("second receive done");
        host_val <= 1'b1;
        foreach (rsv[k]) begin
            wr(8'h42, rsv[k]);
            wt(10);
            cmp1(pin1_oe_n_o, 1'b1);
            cmp1(transmitter_disable_o, 1'b0);
        end
        $display("reserved codes done");
        print_verdict;
    end
endmodule
`default_nettype wire
